// file: cif_eoi_pkg.sv
/*
  Shared constants for the end-of-interrupt / deactivate completion block.
  Assumes a single clock domain and system-register writes decoded by the core.
*/
package cif_eoi_pkg;

  // Coprocessor write encoding fields
  localparam logic [2:0] OPC1_VAL        = 3'h0;
  localparam logic [2:0] OPC2_VAL        = 3'h1;
  localparam logic [3:0] CRN_VAL         = 4'hC;
  localparam logic [3:0] CRM_DEACT       = 4'hB;
  localparam logic [3:0] CRM_G0END       = 4'h8;

  // Field layout of both write-only registers
  localparam int ID_MSB        = 23;
  localparam int ID_W          = 24;
  localparam int ID16_MSB      = 15;

  // Identifier width field encodings
  localparam logic [2:0] IDW_16  = 3'h0;
  localparam logic [2:0] IDW_24  = 3'h1;

  // Special identifiers occupy this range
  localparam logic [23:0] SPECIAL_LO = 24'h0003FC;
  localparam logic [23:0] SPECIAL_HI = 24'h0003FF;

  // Privilege levels
  typedef enum logic [1:0] {
    LVL_USER   = 2'b00,
    LVL_KERNEL = 2'b01,
    LVL_HYP    = 2'b10,
    LVL_MON    = 2'b11
  } level_t;

  // Outcome of one write
  typedef enum logic [2:0] {
    OUT_DONE    = 3'b000,
    OUT_VIRT    = 3'b001,
    OUT_UNDEF   = 3'b010,
    OUT_TRAP_H  = 3'b011,
    OUT_TRAP_M  = 3'b100,
    OUT_IGNORED = 3'b101
  } outcome_t;

endpackage

// file: cif_eoi_if.sv
/*
  Interface carrying one decoded completion command between the access checker
  and the top module. Assumes both ends share the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface cif_eoi_if;
  import cif_eoi_pkg::*;
  logic             valid;
  logic             is_deact;
  logic             split;
  outcome_t         outcome;
  logic [ID_W-1:0]  id;

  modport checker_end (output valid, output is_deact, output split, output outcome, output id);
  modport top_end     (input valid, input is_deact, input split, input outcome, input id);
endinterface
`default_nettype wire

// file: cif_eoi_check.sv
/*
  Combinational access checker: decodes the coprocessor write, selects the
  split bit, and resolves redirection, undefined and trap outcomes.
  Assumes write inputs are synchronous and stable in the strobe cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module cif_eoi_check
  import cif_eoi_pkg::*;
(
  // Write request
  input  wire logic        wr_i,
  input  wire logic [2:0]  opc1_i,
  input  wire logic [2:0]  opc2_i,
  input  wire logic [3:0]  crn_i,
  input  wire logic [3:0]  crm_i,
  input  wire logic [31:0] data_i,
  // Context
  input  wire logic [1:0]  level_i,
  input  wire logic        nonsecure_i,
  input  wire logic        has_mon_i,
  input  wire logic        fmo_i,
  input  wire logic        imo_i,
  input  wire logic        monitor_route_fast_interrupt_i,
  input  wire logic        monitor_route_normal_interrupt_i,
  input  wire logic        sre_k_i,
  input  wire logic        sre_h_i,
  input  wire logic        sre_m_i,
  input  wire logic        t12_i,
  input  wire logic        tc_i,
  input  wire logic        group0_sysreg_trap_i,
  input  wire logic        split_ctl_i,
  input  wire logic        split_s_i,
  input  wire logic        split_ns_i,
  input  wire logic        split_mon_i,
  input  wire logic [2:0]  idw_i,
  // Decoded command
  cif_eoi_if.checker_end   cmd
);
  logic      hit_d;
  logic      hit_e;
  logic      enab;
  logic      nsk;
  logic [23:0] id;

  always_comb begin
    hit_d = wr_i && opc1_i == OPC1_VAL && opc2_i == OPC2_VAL && crn_i == CRN_VAL
            && crm_i == CRM_DEACT; // RULE_21
    hit_e = wr_i && opc1_i == OPC1_VAL && opc2_i == OPC2_VAL && crn_i == CRN_VAL
            && crm_i == CRM_G0END; // RULE_22
    nsk   = nonsecure_i && level_i == LVL_KERNEL;
    // Upper reserved bits forced to zero; narrow ids also clear 23:16
    id = data_i[ID_MSB:0]; // RULE_02
    if (idw_i != IDW_24) begin
      id[ID_MSB:ID16_MSB+1] = '0; // RULE_03 RULE_24
    end
    case (level_i)
      LVL_KERNEL: enab = sre_k_i;
      LVL_HYP:    enab = sre_h_i;
      LVL_MON:    enab = sre_m_i;
      default:    enab = 1'b0;
    endcase
    // Split bit source follows monitor presence and security state
    if (!has_mon_i) cmd.split = split_ctl_i; // RULE_15
    else if (level_i == LVL_MON) cmd.split = split_mon_i; // RULE_15
    else cmd.split = nonsecure_i ? split_ns_i : split_s_i; // RULE_15
    cmd.valid    = hit_d || hit_e;
    cmd.is_deact = hit_d;
    cmd.id       = id;
    cmd.outcome  = OUT_DONE;
    // Redirection wins: the virtual register is accessed instead
    if (hit_d && nsk && (fmo_i || imo_i)) cmd.outcome = OUT_VIRT; // RULE_04 RULE_05
    else if (hit_e && nsk && fmo_i) cmd.outcome = OUT_VIRT; // RULE_18
    else if (level_i == LVL_USER || !enab) cmd.outcome = OUT_UNDEF; // RULE_08
    else if (nsk && t12_i) cmd.outcome = OUT_TRAP_H; // RULE_09
    else if (hit_d && nsk && tc_i) cmd.outcome = OUT_TRAP_H; // RULE_10
    else if (hit_e && nsk && group0_sysreg_trap_i) cmd.outcome = OUT_TRAP_H; // RULE_19
    else if (hit_d && has_mon_i && monitor_route_fast_interrupt_i && monitor_route_normal_interrupt_i && level_i != LVL_MON)
      cmd.outcome = OUT_TRAP_M; // RULE_11
    else if (hit_e && has_mon_i && monitor_route_fast_interrupt_i && level_i != LVL_MON)
      cmd.outcome = OUT_TRAP_M; // RULE_20
    else if (hit_d && !cmd.split) cmd.outcome = OUT_IGNORED; // RULE_06 RULE_23
    else if (hit_e && id >= SPECIAL_LO && id <= SPECIAL_HI)
      cmd.outcome = OUT_IGNORED; // RULE_17
  end
endmodule
`default_nettype wire

// file: cif_eoi_top.sv
/*
  Completion logic of the CPU interface: group 0 end-of-interrupt and
  deactivate writes. Issues distributor deactivations, priority drops,
  virtual redirection, trap and undefined reports.
  Assumes the core presents one decoded write per strobe cycle.
*/
// Notes on behaviour
// (RULE_01) Split mode: deactivate write deactivates given id
// (RULE_02) 32-bit registers, id in 23:0
// (RULE_03) 16-bit ids zero bits 23:16
// (RULE_04) Routed kernel writes go to virtual deactivate
// (RULE_05) Physical deactivate reachable only unrouted; write-only
// (RULE_06) Deactivate without split is ignored, optional error
// (RULE_07) Deactivate before end still deactivates at distributor
// (RULE_08) Disabled level makes writes undefined
// (RULE_09) Coprocessor 12 trap sends kernel writes to hypervisor
// (RULE_10) Common trap sends kernel deactivate to hypervisor
// (RULE_11) Both monitor routes trap deactivate to monitor
// (RULE_12) Software writes end register after group 0 handling
// (RULE_13) No split: end drops priority and deactivates
// (RULE_14) Split: end drops priority only
// (RULE_15) Split bit chosen by monitor, level, security
// (RULE_16) Software ends only last valid acknowledged id
// (RULE_17) Special id end writes are ignored
// (RULE_18) Fast route redirects kernel end to virtual
// (RULE_19) Group 0 trap sends kernel end to hypervisor
// (RULE_20) Fast monitor route traps end to monitor
// (RULE_21) Deactivate encoding: 0,1,c12,c11
// (RULE_22) End encoding: 0,1,c12,c8
// (RULE_23) Split clear: deactivate unpredictable, here ignored
// (RULE_24) Width field read-only: 000 16, 001 24
// (RULE_25) Deactivate is one message; drop clears top active bit
`timescale 1ns/10ps
`default_nettype none
module cif_eoi_top
  import cif_eoi_pkg::*;
#(
  parameter int PRIO_LEVELS = 32,
  parameter bit SEI_SUPPORT = 1'b1
)(
  // Clock and reset
  input  wire logic                   SYS_CLK_I,
  input  wire logic                   RST_I,
  // Coprocessor write
  input  wire logic                   WR_I,
  input  wire logic [2:0]             OPC1_I,
  input  wire logic [2:0]             OPC2_I,
  input  wire logic [3:0]             CRN_I,
  input  wire logic [3:0]             CRM_I,
  input  wire logic [31:0]            DATA_I,
  // Execution context
  input  wire logic [1:0]             LEVEL_I,
  input  wire logic                   NONSECURE_I,
  input  wire logic                   HAS_MONITOR_I,
  input  wire logic                   FAST_IRQ_VIRTUAL_ROUTE_I,
  input  wire logic                   NORMAL_IRQ_VIRTUAL_ROUTE_I,
  input  wire logic                   MONITOR_ROUTE_FAST_INTERRUPT_I,
  input  wire logic                   MONITOR_ROUTE_NORMAL_INTERRUPT_I,
  input  wire logic                   KERNEL_SRE_I,
  input  wire logic                   HYP_SRE_I,
  input  wire logic                   MONITOR_SRE_I,
  input  wire logic                   SYSREG_C12_TRAP_I,
  input  wire logic                   COMMON_REG_TRAP_I,
  input  wire logic                   GROUP0_SYSREG_TRAP_I,
  input  wire logic                   SPLIT_CTL_I,
  input  wire logic                   SPLIT_SECURE_I,
  input  wire logic                   SPLIT_NONSECURE_I,
  input  wire logic                   SPLIT_MONITOR_I,
  input  wire logic [2:0]             IDENTIFIER_WIDTH_I,
  // Active priorities set by acknowledge logic
  input  wire logic [PRIO_LEVELS-1:0] ACTIVE_SET_I,
  // Distributor and core results
  output logic                        DEACT_VALID_O,
  output logic [ID_W-1:0]             DEACT_ID_O,
  output logic                        VIRT_DEACT_O,
  output logic                        VIRT_G0END_O,
  output logic [ID_W-1:0]             VIRT_ID_O,
  output logic                        UNDEF_O,
  output logic                        TRAP_HYP_O,
  output logic                        TRAP_MON_O,
  output logic                        SEI_O,
  output logic [PRIO_LEVELS-1:0]      ACTIVE_PRIO_O
);
  // Refused at elaboration: the drop logic needs at least two levels
  if (PRIO_LEVELS < 2 || PRIO_LEVELS > 256) begin : g_bad_levels
    $error("PRIO_LEVELS out of range");
  end

  cif_eoi_if cmd ();

  cif_eoi_check u_check (
    .wr_i        (WR_I),
    .opc1_i      (OPC1_I),
    .opc2_i      (OPC2_I),
    .crn_i       (CRN_I),
    .crm_i       (CRM_I),
    .data_i      (DATA_I),
    .level_i     (LEVEL_I),
    .nonsecure_i (NONSECURE_I),
    .has_mon_i   (HAS_MONITOR_I),
    .fmo_i       (FAST_IRQ_VIRTUAL_ROUTE_I),
    .imo_i       (NORMAL_IRQ_VIRTUAL_ROUTE_I),
    .monitor_route_fast_interrupt_i   (MONITOR_ROUTE_FAST_INTERRUPT_I),
    .monitor_route_normal_interrupt_i   (MONITOR_ROUTE_NORMAL_INTERRUPT_I),
    .sre_k_i     (KERNEL_SRE_I),
    .sre_h_i     (HYP_SRE_I),
    .sre_m_i     (MONITOR_SRE_I),
    .t12_i       (SYSREG_C12_TRAP_I),
    .tc_i        (COMMON_REG_TRAP_I),
    .group0_sysreg_trap_i     (GROUP0_SYSREG_TRAP_I),
    .split_ctl_i (SPLIT_CTL_I),
    .split_s_i   (SPLIT_SECURE_I),
    .split_ns_i  (SPLIT_NONSECURE_I),
    .split_mon_i (SPLIT_MONITOR_I),
    .idw_i       (IDENTIFIER_WIDTH_I),
    .cmd         (cmd.checker_end)
  );

  logic done;
  logic deact_d;
  logic drop_d;
  logic [PRIO_LEVELS-1:0] top_bit;
  logic [PRIO_LEVELS-1:0] active_d;

  always_comb begin
    done = cmd.valid && cmd.outcome == OUT_DONE;
    // Deactivate regardless of whether a drop happened first
    deact_d = done && (cmd.is_deact || !cmd.split); // RULE_01 RULE_07 RULE_13
    drop_d  = done && !cmd.is_deact; // RULE_14
    // Lowest index is the highest priority
    top_bit = '0;
    for (int i = PRIO_LEVELS - 1; i >= 0; i--) begin
      if (ACTIVE_PRIO_O[i]) begin
        top_bit = '0;
        top_bit[i] = 1'b1;
      end
    end
    // Set wins over drop so a new acknowledge is never lost
    active_d = ACTIVE_PRIO_O;
    if (drop_d) active_d = active_d & ~top_bit; // RULE_25
    active_d = active_d | ACTIVE_SET_I;
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ACTIVE_PRIO_O <= '0;
    end else begin
      ACTIVE_PRIO_O <= active_d;
    end
  end

  // One message per deactivation
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      DEACT_VALID_O <= 1'b0;
      DEACT_ID_O    <= '0;
    end else begin
      DEACT_VALID_O <= deact_d; // RULE_25
      if (deact_d) DEACT_ID_O <= cmd.id;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      VIRT_DEACT_O <= 1'b0;
      VIRT_G0END_O <= 1'b0;
      VIRT_ID_O    <= '0;
      UNDEF_O      <= 1'b0;
      TRAP_HYP_O   <= 1'b0;
      TRAP_MON_O   <= 1'b0;
      SEI_O        <= 1'b0;
    end else begin
      VIRT_DEACT_O <= cmd.valid && cmd.outcome == OUT_VIRT && cmd.is_deact; // RULE_04
      VIRT_G0END_O <= cmd.valid && cmd.outcome == OUT_VIRT && !cmd.is_deact; // RULE_18
      if (cmd.valid && cmd.outcome == OUT_VIRT) VIRT_ID_O <= cmd.id;
      UNDEF_O      <= cmd.valid && cmd.outcome == OUT_UNDEF; // RULE_08
      TRAP_HYP_O   <= cmd.valid && cmd.outcome == OUT_TRAP_H; // RULE_09
      TRAP_MON_O   <= cmd.valid && cmd.outcome == OUT_TRAP_M; // RULE_11 RULE_20
      // Only the split-clear deactivate raises the error, not special ids
      SEI_O <= SEI_SUPPORT && cmd.valid && cmd.outcome == OUT_IGNORED
               && cmd.is_deact; // RULE_06
    end
  end
endmodule
`default_nettype wire

// file: cif_eoi_asserts.sv
/*
  Checker for cif_eoi_top: result pulses against the write and its context.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
`default_nettype none
module cif_eoi_asserts
  import cif_eoi_pkg::*;
(
  // Clock, reset and write
  input wire logic            SYS_CLK_I, RST_I, WR_I,
  input wire logic [2:0]      OPC1_I, OPC2_I, IDENTIFIER_WIDTH_I,
  input wire logic [3:0]      CRN_I, CRM_I,
  input wire logic [31:0]     DATA_I,
  // Context
  input wire logic [1:0]      LEVEL_I,
  input wire logic            NONSECURE_I, HAS_MONITOR_I, FAST_IRQ_VIRTUAL_ROUTE_I,
  input wire logic            NORMAL_IRQ_VIRTUAL_ROUTE_I, KERNEL_SRE_I,
  input wire logic            SYSREG_C12_TRAP_I, SPLIT_CTL_I,
  // Results
  input wire logic            DEACT_VALID_O, VIRT_DEACT_O, VIRT_G0END_O,
  input wire logic            UNDEF_O, TRAP_HYP_O, TRAP_MON_O, SEI_O,
  input wire logic [ID_W-1:0] DEACT_ID_O
);
  wire logic enc = WR_I && OPC1_I == OPC1_VAL && OPC2_I == OPC2_VAL && CRN_I == CRN_VAL;
  wire logic dw = enc && CRM_I == CRM_DEACT;
  wire logic ew = enc && CRM_I == CRM_G0END;
  wire logic sk = LEVEL_I == LVL_KERNEL && !NONSECURE_I && KERNEL_SRE_I;
  wire logic nsk = LEVEL_I == LVL_KERNEL && NONSECURE_I;
  wire logic rte = FAST_IRQ_VIRTUAL_ROUTE_I || NORMAL_IRQ_VIRTUAL_ROUTE_I;
  // Every result pulse, monitor trap included, so no write yields two
  wire logic [6:0] res = {DEACT_VALID_O, VIRT_DEACT_O, VIRT_G0END_O, UNDEF_O,
                          TRAP_HYP_O, TRAP_MON_O, SEI_O};
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  AST_VIRT_DEACT: assert property (dw && nsk && rte |=> VIRT_DEACT_O && !DEACT_VALID_O)
    else $error("routed deactivate not redirected");
  AST_VIRT_END: assert property (ew && nsk |=> VIRT_G0END_O == $past(FAST_IRQ_VIRTUAL_ROUTE_I))
    else $error("end redirect does not follow fast route");
  AST_UNDEF: assert property ((dw || ew) && LEVEL_I == LVL_KERNEL && !KERNEL_SRE_I && !nsk |=> UNDEF_O)
    else $error("disabled kernel write not undefined");
  AST_C12_TRAP: assert property ((dw || ew) && nsk && !rte && KERNEL_SRE_I && SYSREG_C12_TRAP_I
    |=> TRAP_HYP_O)
    else $error("c12 trap missed");
  AST_SEI: assert property (dw && sk && !HAS_MONITOR_I && !SPLIT_CTL_I |=> SEI_O && !DEACT_VALID_O)
    else $error("deactivate without split not ignored");
  AST_ID: assert property (DEACT_VALID_O |-> DEACT_ID_O == ($past(IDENTIFIER_WIDTH_I) == IDW_24 ?
    $past(DATA_I[23:0]) : {8'h00, $past(DATA_I[15:0])}))
    else $error("deactivate id not masked");
  AST_CAUSE: assert property (|res |-> $past(dw || ew))
    else $error("result without a taken write");
  AST_ONE: assert property (|res |-> $onehot(res))
    else $error("more than one result for a write");
  AST_SPECIAL: assert property (ew && DATA_I[23:0] inside {[SPECIAL_LO:SPECIAL_HI]}
    |=> !DEACT_VALID_O)
    else $error("special id end not ignored");
endmodule
bind cif_eoi_top cif_eoi_asserts i_chk (.*);
`default_nettype wire

// file: cif_core_model.sv
/*
  Core model: issues coprocessor writes to the completion registers.
  Assumes one caller at a time, clocked by the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module cif_core_model
  import cif_eoi_pkg::*;
(
  // Clock
  input  wire logic  clk_i,
  // Coprocessor write
  output logic       wr_o,
  output logic [2:0] opc1_o,
  output logic [2:0] opc2_o,
  output logic [3:0] crn_o,
  output logic [3:0] crm_o,
  output logic [31:0] data_o
);
  initial begin
    wr_o = 1'b0;
    opc1_o = 3'h7;
    opc2_o = 3'h6;
    crn_o = 4'h3;
    crm_o = 4'h4;
    data_o = 32'hA5A5_A5A5;
  end
  task automatic coprocessor_write_instruction(input logic [3:0] crm, input logic [31:0] data);
    @(posedge clk_i);
    wr_o <= 1'b1;
    opc1_o <= OPC1_VAL;
    opc2_o <= OPC2_VAL;
    crn_o <= CRN_VAL;
    crm_o <= crm;
    data_o <= data;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // Register and data lines invert (opcodes and crn hold) so stale values are never mistaken for a write
    crm_o <= ~crm;
    data_o <= ~data;
  endtask
endmodule
`default_nettype wire

// file: tb_cif_eoi_top.sv
/*
  Testbench for cif_eoi_top: hand-written scenarios through the core model.
  Assumes at most one result pulse, one cycle after each write.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_cif_eoi_top;
  import cif_eoi_pkg::*;
  typedef struct packed {
    logic [1:0] lv;
    logic ns, hm, fr, nr, mf, mn, sk, sh, sm, c12, tc, t0, sc, ss, sn, sx;
    logic [2:0] iw;
  } ctx_t;
  localparam ctx_t DEF = '{lv: LVL_KERNEL, sk: 1'b1, sh: 1'b1, sm: 1'b1, iw: IDW_24, default: '0};
  logic clk = 1'b0;
  logic rst = 1'b1;
  ctx_t c = DEF;
  ctx_t n;
  logic [31:0] aset = 32'h0;
  int n_errors = 0;
  int n_tests = 0;
  logic wr, dv, vd, vg, ud, th, tm, se;
  logic [2:0] o1, o2;
  logic [3:0] cn, cm;
  logic [31:0] d, ap;
  logic [23:0] did, vid;
  always #10 clk = ~clk;
  cif_core_model i_core (.clk_i(clk), .wr_o(wr), .opc1_o(o1), .opc2_o(o2), .crn_o(cn),
    .crm_o(cm), .data_o(d));
  cif_eoi_top i_dut (.SYS_CLK_I(clk), .RST_I(rst), .WR_I(wr), .OPC1_I(o1), .OPC2_I(o2),
    .CRN_I(cn), .CRM_I(cm), .DATA_I(d), .LEVEL_I(c.lv), .NONSECURE_I(c.ns),
    .HAS_MONITOR_I(c.hm), .FAST_IRQ_VIRTUAL_ROUTE_I(c.fr), .NORMAL_IRQ_VIRTUAL_ROUTE_I(c.nr),
    .MONITOR_ROUTE_FAST_INTERRUPT_I(c.mf), .MONITOR_ROUTE_NORMAL_INTERRUPT_I(c.mn),
    .KERNEL_SRE_I(c.sk), .HYP_SRE_I(c.sh), .MONITOR_SRE_I(c.sm), .SYSREG_C12_TRAP_I(c.c12),
    .COMMON_REG_TRAP_I(c.tc), .GROUP0_SYSREG_TRAP_I(c.t0), .SPLIT_CTL_I(c.sc),
    .SPLIT_SECURE_I(c.ss), .SPLIT_NONSECURE_I(c.sn), .SPLIT_MONITOR_I(c.sx),
    .IDENTIFIER_WIDTH_I(c.iw), .ACTIVE_SET_I(aset), .DEACT_VALID_O(dv), .DEACT_ID_O(did),
    .VIRT_DEACT_O(vd), .VIRT_G0END_O(vg), .VIRT_ID_O(vid), .UNDEF_O(ud), .TRAP_HYP_O(th),
    .TRAP_MON_O(tm), .SEI_O(se), .ACTIVE_PRIO_O(ap));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apply(input ctx_t x);
    @(posedge clk);
    c <= x;
  endtask
  task automatic act(input logic [31:0] bits);
    @(posedge clk);
    aset <= bits;
    @(posedge clk);
    aset <= 32'h0;
  endtask
  // Result order: deact, vdeact, vend, undef, trap hyp, trap mon, error
  task automatic wr_chk(input logic [3:0] crm, input logic [31:0] data, input logic [6:0] exp);
    i_core.coprocessor_write_instruction(crm, data);
    #1;
    chk({dv, vd, vg, ud, th, tm, se}, exp);
  endtask
  task automatic pair(input ctx_t x, input logic [6:0] ee, input logic [6:0] ed);
    apply(x);
    wr_chk(CRM_G0END, 32'h21, ee);
    wr_chk(CRM_DEACT, 32'h21, ed);
  endtask
  task automatic t_end;
    n = DEF;
    apply(n);
    act(32'h6);
    wr_chk(CRM_G0END, 32'h5, 7'h40);
    chk({did, ap[7:0]}, 32'h05_04);
    n.sc = 1'b1;
    apply(n);
    wr_chk(CRM_G0END, 32'h7, 7'h00);
    chk(ap, 32'h0);
    wr_chk(CRM_DEACT, 32'h7, 7'h40);
    chk(did, 24'h7);
    act(32'h1);
    wr_chk(CRM_DEACT, 32'h9, 7'h40);
    chk(ap, 32'h1);
    for (int i = 32'h3FF; i >= 32'h3FB; i--) begin
      n.sc = 1'b0;
      apply(n);
      wr_chk(CRM_G0END, i, (i == 32'h3FB) ? 7'h40 : 7'h00);
      chk(ap, (i == 32'h3FB) ? 32'h0 : 32'h1);
    end
    $display("end and deactivate done");
  endtask
  task automatic t_modes;
    for (int k = 0; k < 6; k++) begin
      n = DEF;
      n.hm = 1'b1;
      n.lv = (k % 3 == 2) ? LVL_MON : LVL_KERNEL;
      n.ns = (k % 3 == 1);
      {n.ss, n.sn, n.sx} = (k < 3) ? (3'h4 >> k) : ~(3'h4 >> (k - 3));
      // Neighbouring encoding: must be ignored whatever the context
      wr_chk(CRM_DEACT ^ 4'h1, 32'h20, 7'h00);
      apply(n);
      wr_chk(CRM_DEACT, 32'h20, (k < 3) ? 7'h40 : 7'h01);
    end
    n = DEF;
    n.sc = 1'b1;
    for (int k = 0; k < 3; k++) begin
      n.iw = (k == 0) ? IDW_24 : ((k == 1) ? IDW_16 : 3'h5);
      apply(n);
      wr_chk(CRM_DEACT, 32'hFF12_3456, 7'h40);
      chk(did, (k == 0) ? 24'h12_3456 : 24'h00_3456);
    end
    $display("split and width done");
  endtask
  task automatic t_access;
    for (int k = 0; k < 3; k++) begin
      n = DEF;
      n.ns = 1'b1;
      {n.fr, n.nr} = 2'h2 >> k;
      apply(n);
      wr_chk(CRM_G0END, 32'h33, (k == 0) ? 7'h10 : 7'h40);
      wr_chk(CRM_DEACT, 32'h33, (k == 2) ? 7'h01 : 7'h20);
      chk(vid, 24'h33);
    end
    n = DEF;
    n.ns = 1'b1;
    n.sk = 1'b0;
    pair(n, 7'h08, 7'h08);
    n.sk = 1'b1;
    n.c12 = 1'b1;
    pair(n, 7'h04, 7'h04);
    n.c12 = 1'b0;
    n.tc = 1'b1;
    pair(n, 7'h40, 7'h04);
    n.tc = 1'b0;
    n.t0 = 1'b1;
    pair(n, 7'h04, 7'h01);
    n.t0 = 1'b0;
    n.hm = 1'b1;
    n.mf = 1'b1;
    pair(n, 7'h02, 7'h01);
    n.lv = LVL_HYP;
    n.mn = 1'b1;
    pair(n, 7'h02, 7'h02);
    n.sh = 1'b0;
    pair(n, 7'h08, 7'h08);
    $display("access checks done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({dv, vd, vg, ud, th, tm, se, ap[24:0]}, 32'h0);
    t_end();
    t_modes();
    t_access();
    report_and_stop();
  end
endmodule
`default_nettype wire
